// [core/sdpa_defines.svh]
// constants for the sysref divider phase alignment block
`ifndef SDPA_DEFINES_SVH
`define SDPA_DEFINES_SVH

// =====================================================================
// register offsets
`define SDPA_ADDR_W 12
`define SDPA_OFS_DIV_RATIO 12'h0108
`define SDPA_OFS_LOCAL_PHASE 12'h0109
`define SDPA_OFS_ALIGN_CTRL 12'h010A
`define SDPA_OFS_ALIGN_STATUS 12'h010B
`define SDPA_OFS_SYSREF_MODE 12'h0120
`define SDPA_OFS_CAPTURE_PHASE 12'h0129

// =====================================================================
// field positions
`define SDPA_CTRL_AUTO_BIT 7
`define SDPA_CTRL_NEG_HI 3
`define SDPA_CTRL_NEG_LO 2
`define SDPA_CTRL_POS_HI 1
`define SDPA_CTRL_POS_LO 0
`define SDPA_MODE_HI 2
`define SDPA_MODE_LO 1

// =====================================================================
// ratio codes and phase masks in half clock units
`define SDPA_RATIO_DIV1 3'h0
`define SDPA_RATIO_DIV2 3'h1
`define SDPA_RATIO_DIV4 3'h3
`define SDPA_MASK_DIV1 4'h1
`define SDPA_MASK_DIV2 4'h3
`define SDPA_MASK_DIV4 4'h7
`define SDPA_HALF_STEP 4'h2

// =====================================================================
// reset values
`define SDPA_RST_BYTE 8'h00
`define SDPA_RST_RATIO 3'h0
`define SDPA_RST_NIBBLE 4'h0
`define SDPA_RST_SKEW 2'h0
`define SDPA_RST_MODE 2'h0

`endif

// [core/sdpa_pkg.sv]
// types for the sysref divider phase alignment block
package sdpa_pkg;

  // =====================================================================
  // register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sdpa_bus_s;

  // =====================================================================
  // complete block state
  typedef struct packed {
    logic [2:0] div_ratio;
    logic [3:0] local_phase;
    logic auto_en;
    logic [1:0] neg_skew;
    logic [1:0] pos_skew;
    logic [1:0] sysref_mode;
    logic [3:0] sysref_offset;
    logic [3:0] capture_phase;
    logic [3:0] half_cnt;
    logic sysref_prev;
    logic [7:0] rd_data;
    logic div_tick;
    logic div_tick_half;
    logic [3:0] div_phase;
    logic sysref_ignored;
    logic realign;
  } sdpa_state_s;

endpackage

// [core/sdpa_top.sv]
// sample clock divider with sysref driven phase realignment
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "sdpa_defines.svh"

module sdpa_top
  import sdpa_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire sdpa_bus_s bus_in,
  input wire logic sysref_in,
  input wire logic sysref_late_in,
  output logic [7:0] rd_data_out,
  output logic div_tick_out,
  output logic div_tick_half_out,
  output logic [3:0] div_phase_out,
  output logic sysref_ignored_out,
  output logic realign_out
);

  // =====================================================================
  // decoding helpers

  // phase counter wraps at twice the ratio, counted in half clocks
  function automatic logic [3:0] period_mask(input logic [2:0] ratio);
    case (ratio)
      `SDPA_RATIO_DIV1: period_mask = `SDPA_MASK_DIV1;
      `SDPA_RATIO_DIV2: period_mask = `SDPA_MASK_DIV2;
      `SDPA_RATIO_DIV4: period_mask = `SDPA_MASK_DIV4;
      // undefined codes fall back to the undivided clock
      default: period_mask = `SDPA_MASK_DIV1;
    endcase
  endfunction

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    addr_is = (a == ofs);
  endfunction

  // =====================================================================
  // state

  sdpa_state_s state;
  sdpa_state_s next_state;

  logic [3:0] mask;
  logic [3:0] cap_phase;
  logic [3:0] dist_before;
  logic [3:0] eff_offset;
  logic [3:0] shifted;
  logic sysref_edge;
  logic capture_en;
  logic in_neg_window;
  logic in_pos_window;
  logic accept;

  always_comb begin
    next_state = state;
    mask = period_mask(state.div_ratio);
    next_state.div_tick = 1'b0;
    next_state.div_tick_half = 1'b0;
    next_state.sysref_ignored = 1'b0;
    next_state.realign = 1'b0;
    next_state.rd_data = `SDPA_RST_BYTE;

    // capture is armed only while the sysref mode field is non-zero
    capture_en = (state.sysref_mode != `SDPA_RST_MODE);
    sysref_edge = sysref_in & ~state.sysref_prev & capture_en;
    next_state.sysref_prev = sysref_in;

    // divider phase at the sysref transition, in half clocks
    cap_phase = (state.half_cnt | {3'h0, sysref_late_in}) & mask;
    dist_before = (4'h0 - cap_phase) & mask;

    // windows are only consulted with auto adjust on
    in_neg_window = state.auto_en && (cap_phase != 4'h0) &&
      (dist_before <= {2'h0, state.neg_skew});
    in_pos_window = state.auto_en && (cap_phase != 4'h0) &&
      (cap_phase <= {2'h0, state.pos_skew});
    accept = sysref_edge && state.auto_en && !in_neg_window && !in_pos_window;

    // =====================================================================
    // divider phase counter
    next_state.half_cnt = (state.half_cnt + `SDPA_HALF_STEP) & mask;

    if (sysref_edge) begin
      next_state.capture_phase = cap_phase;
    end
    if (sysref_edge && state.auto_en && !accept) begin
      next_state.sysref_ignored = 1'b1;
    end
    if (accept) begin
      // restart the divider at the accepted edge, keep its phase for offset
      next_state.sysref_offset = cap_phase;
      next_state.half_cnt = `SDPA_RST_NIBBLE;
      next_state.realign = 1'b1;
    end
    // with auto adjust off the counter free runs, sysref only recorded

    // effective offset: applied sysref phase plus local offset, local offset alone with auto adjust off
    if (state.auto_en) begin
      eff_offset = (state.sysref_offset + state.local_phase) & mask;
    end else begin
      eff_offset = state.local_phase & mask;
    end
    shifted = (state.half_cnt - eff_offset) & mask;
    next_state.div_phase = shifted;
    if (shifted[3:1] == 3'h0) begin
      next_state.div_tick = 1'b1;
      // odd offset: divided edge lands on the inverted clock
      next_state.div_tick_half = shifted[0];
    end

    // =====================================================================
    // register writes
    if (bus_in.wr) begin
      if (addr_is(bus_in.addr, `SDPA_OFS_DIV_RATIO)) begin
        next_state.div_ratio = bus_in.wdata[2:0];
      end
      if (addr_is(bus_in.addr, `SDPA_OFS_LOCAL_PHASE)) begin
        next_state.local_phase = bus_in.wdata[3:0];
      end
      if (addr_is(bus_in.addr, `SDPA_OFS_ALIGN_CTRL)) begin
        // no check of window sum against ratio, software keeps it
        next_state.auto_en = bus_in.wdata[`SDPA_CTRL_AUTO_BIT];
        next_state.neg_skew = bus_in.wdata[`SDPA_CTRL_NEG_HI:`SDPA_CTRL_NEG_LO];
        next_state.pos_skew = bus_in.wdata[`SDPA_CTRL_POS_HI:`SDPA_CTRL_POS_LO];
      end
      if (addr_is(bus_in.addr, `SDPA_OFS_SYSREF_MODE)) begin
        next_state.sysref_mode = bus_in.wdata[`SDPA_MODE_HI:`SDPA_MODE_LO];
      end
    end

    // =====================================================================
    // register reads, data one cycle after the strobe
    if (bus_in.rd) begin
      case (bus_in.addr)
        `SDPA_OFS_DIV_RATIO: next_state.rd_data = {5'h00, state.div_ratio};
        `SDPA_OFS_LOCAL_PHASE: next_state.rd_data = {4'h0, state.local_phase};
        `SDPA_OFS_ALIGN_CTRL: next_state.rd_data =
          {state.auto_en, 3'h0, state.neg_skew, state.pos_skew};
        `SDPA_OFS_ALIGN_STATUS: next_state.rd_data = {4'h0, state.sysref_offset};
        `SDPA_OFS_SYSREF_MODE: next_state.rd_data = {5'h00, state.sysref_mode, 1'b0};
        `SDPA_OFS_CAPTURE_PHASE: next_state.rd_data = {4'h0, state.capture_phase};
        default: next_state.rd_data = `SDPA_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state.div_ratio <= `SDPA_RST_RATIO;
      state.local_phase <= `SDPA_RST_NIBBLE;
      state.auto_en <= 1'b0;
      state.neg_skew <= `SDPA_RST_SKEW;
      state.pos_skew <= `SDPA_RST_SKEW;
      state.sysref_mode <= `SDPA_RST_MODE;
      state.sysref_offset <= `SDPA_RST_NIBBLE;
      state.capture_phase <= `SDPA_RST_NIBBLE;
      state.half_cnt <= `SDPA_RST_NIBBLE;
      state.sysref_prev <= 1'b0;
      state.rd_data <= `SDPA_RST_BYTE;
      state.div_tick <= 1'b0;
      state.div_tick_half <= 1'b0;
      state.div_phase <= `SDPA_RST_NIBBLE;
      state.sysref_ignored <= 1'b0;
      state.realign <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // =====================================================================
  // outputs straight from state flops
  assign rd_data_out = state.rd_data;
  assign div_tick_out = state.div_tick;
  assign div_tick_half_out = state.div_tick_half;
  assign div_phase_out = state.div_phase;
  assign sysref_ignored_out = state.sysref_ignored;
  assign realign_out = state.realign;

endmodule // sdpa_top
`default_nettype wire

// [sim/sdpa_props.sv]
// checker for the sysref divider phase alignment block
`timescale 1ns/100ps
`default_nettype none
module sdpa_props
  import sdpa_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire sdpa_bus_s bus_in,
  input wire logic sysref_in,
  input wire logic sysref_late_in,
  input wire logic [7:0] rd_data_out,
  input wire logic div_tick_out,
  input wire logic div_tick_half_out,
  input wire logic [3:0] div_phase_out,
  input wire logic sysref_ignored_out,
  input wire logic realign_out
);
  // auto bit mirrored from bus writes, since the checker cannot see registers
  logic auto_q;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) auto_q <= 1'b0;
    else if (bus_in.wr && bus_in.addr == 12'h010A) auto_q <= bus_in.wdata[7];
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // ==========================================================
  // capture outcomes
  one_outcome_a: assert property (realign_out |-> !sysref_ignored_out)
    else $error("realign and ignore together");
  realign_cause_a: assert property (realign_out |-> $past(sysref_in) && !$past(sysref_in, 2))
    else $error("realign without sysref rise");
  ignore_cause_a: assert property (sysref_ignored_out |-> $past(sysref_in) && !$past(sysref_in, 2))
    else $error("ignore without sysref rise");
  realign_pulse_a: assert property (realign_out |=> !realign_out)
    else $error("realign longer than a cycle");
  ignore_pulse_a: assert property (sysref_ignored_out |=> !sysref_ignored_out)
    else $error("ignore longer than a cycle");
  auto_off_a: assert property (!auto_q |=> !realign_out && !sysref_ignored_out)
    else $error("capture acted with auto off");
  // ==========================================================
  // divider outputs
  phase_range_a: assert property (div_phase_out[3] == 1'b0)
    else $error("phase beyond widest mask");
  half_tick_a: assert property (div_tick_half_out |-> div_tick_out)
    else $error("half flag without tick");
  cover property (realign_out);
  cover property (sysref_ignored_out);
  cover property (div_tick_half_out);
endmodule // sdpa_props
bind sdpa_top sdpa_props u_sdpa_props (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
  .bus_in(bus_in), .sysref_in(sysref_in), .sysref_late_in(sysref_late_in),
  .rd_data_out(rd_data_out), .div_tick_out(div_tick_out),
  .div_tick_half_out(div_tick_half_out), .div_phase_out(div_phase_out),
  .sysref_ignored_out(sysref_ignored_out), .realign_out(realign_out));
`default_nettype wire

// [sim/sdpa_sysref_gen.sv]
// sysref source model for the phase alignment bench
`timescale 1ns/100ps
`default_nettype none
module sdpa_sysref_gen (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic fire_in,
  input wire logic late_in,
  output logic sysref_out,
  output logic late_out
);
  // one-cycle rise, so two rises are never closer than two cycles;
  // the late flag only means something at the rise, so it toggles elsewhere
  always_ff @(posedge clk_in) begin
    sysref_out <= fire_in && !reset_in;
    late_out <= reset_in ? 1'b0 : (fire_in ? late_in : !late_out);
  end
endmodule // sdpa_sysref_gen
`default_nettype wire

// [sim/sdpa_top_tb.sv]
// self-checking bench for the sysref divider phase alignment block
`timescale 1ns/100ps
`default_nettype none
module sdpa_top_tb import sdpa_pkg::*;;
  logic clk_sys_in, reset_in, fire, late, sr, sr_late, tick, half, ign, realign;
  sdpa_bus_s bus_in;
  logic [7:0] rdat;
  logic [3:0] phase;
  logic [1:0] code;
  int bad_count = 0;
  int checks_done = 0;
  sdpa_top u_sdpa_top (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .bus_in(bus_in),
    .sysref_in(sr), .sysref_late_in(sr_late), .rd_data_out(rdat), .div_tick_out(tick),
    .div_tick_half_out(half), .div_phase_out(phase), .sysref_ignored_out(ign),
    .realign_out(realign));
  sdpa_sysref_gen u_sdpa_sysref_gen (.clk_in(clk_sys_in), .reset_in(reset_in),
    .fire_in(fire), .late_in(late), .sysref_out(sr), .late_out(sr_late));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one access, then an idle cycle so no strobe is assigned twice at one edge
  task automatic op(input logic [11:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_sys_in);
    bus_in <= {a, d, w, !w};
    @(posedge clk_sys_in);
    bus_in <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    op(a, 8'h00, 1'b0);
    #1 chk(rdat, e);
  endtask
  task automatic shoot(input logic l, input logic [1:0] e);
    @(posedge clk_sys_in);
    fire <= 1'b1;
    late <= l;
    @(posedge clk_sys_in);
    fire <= 1'b0;
    // the outcome pulse stands only in the cycle after the rise is sampled
    @(posedge clk_sys_in);
    #1 chk({6'h00, realign, ign}, {6'h00, e});
  endtask
  // at divide by one every cycle ticks and the half flag is the phase lsb
  task automatic ph(input logic [3:0] e);
    repeat (3) @(posedge clk_sys_in);
    #1 chk({4'h0, phase}, {4'h0, e});
    chk({6'h00, tick, half}, {6'h00, 1'b1, e[0]});
  endtask
  task automatic ticks(input logic [2:0] r, input logic [7:0] e);
    logic [7:0] n;
    n = 8'h00;
    op(12'h0108, {5'h00, r}, 1'b1);
    repeat (4) @(posedge clk_sys_in);
    repeat (8) begin
      @(posedge clk_sys_in);
      #1 n = n + {7'h00, tick};
    end
    chk(n, e);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = !clk_sys_in;
  end
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    bad_count++;
    test_done();
  end
  initial begin
    bus_in = '0;
    fire = 1'b0;
    late = 1'b0;
    reset_in = 1'b1;
    repeat (5) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd(12'h010A, 8'h00);
    rd(12'h010B, 8'h00);
    rd(12'h0100, 8'h00);
    $display("reset test done");
    ticks(3'h0, 8'h08);
    ticks(3'h1, 8'h04);
    ticks(3'h3, 8'h02);
    $display("divide test done");
    // ratio code 7 still divides by one, so a late rise at phase 1 falls in any window of 1 or more
    op(12'h0108, 8'h07, 1'b1);
    for (int i = 0; i < 8; i++) begin
      code = i[1:0];
      op(12'h0120, 8'h00, 1'b1);
      op(12'h010A, i[2] ? {4'h8, code, 2'h0} : {6'h20, code}, 1'b1);
      op(12'h0120, 8'h06, 1'b1);
      shoot(1'b1, {code == 2'h0, code != 2'h0});
    end
    rd(12'h010B, 8'h01);
    rd(12'h0129, 8'h01);
    ph(4'h1);
    op(12'h0109, 8'h01, 1'b1);
    ph(4'h0);
    op(12'h0120, 8'h00, 1'b1);
    op(12'h010A, 8'h0F, 1'b1);
    op(12'h0120, 8'h06, 1'b1);
    ph(4'h1);
    shoot(1'b1, 2'b00);
    op(12'h010B, 8'hFF, 1'b1);
    rd(12'h010B, 8'h01);
    op(12'h0120, 8'h00, 1'b1);
    op(12'h010A, 8'h8F, 1'b1);
    op(12'h0120, 8'h06, 1'b1);
    shoot(1'b0, 2'b10);
    rd(12'h010A, 8'h8F);
    rd(12'h010B, 8'h00);
    ph(4'h1);
    $display("alignment test done");
    test_done();
  end
endmodule // sdpa_top_tb
`default_nettype wire
